// ===== tecc_pkg.sv
// Purpose: Shared constants for the elapsed-time capture counter
// Assumes: Single 50 MHz system clock
// Notes: Divide ratios count sampled rising edges of the chosen oscillator
package tecc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int CNT_W = 40;
  localparam int FUNC_W = 8;
  localparam int DIV_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Pin function code that turns a pin into the capture trigger
  localparam logic [FUNC_W-1:0] PIN_FUNC_CAPTURE = 8'h27;

  // Oscillator select and capture source encodings
  localparam logic OSC_SEL_THIRD = 1'h0;
  localparam logic OSC_SEL_SECOND = 1'h1;
  localparam logic SRC_CHIP_SELECT = 1'h0;
  localparam logic SRC_PIN = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Divide ratios
  localparam logic [DIV_W-1:0] DIV_THIRD = 5'h08;
  localparam logic [DIV_W-1:0] DIV_SECOND = 5'h14;
  localparam logic [DIV_W-1:0] DIV_ONE = 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Reset, maximum and step values
  localparam logic [CNT_W-1:0] CNT_RESET = 40'h00_0000_0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 40'hFF_FFFF_FFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 40'h00_0000_0001;
  localparam logic [DIV_W-1:0] DIV_RESET = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Capture arming state, Gray along armed -> locked
  typedef enum logic [1:0] {
    TECC_ARMED = 2'h0,
    TECC_LOCKED = 2'h1
  } tecc_arm_t;

endpackage

// ===== tecc_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Input is asynchronous to CLK
// Notes: Output level changes only when stages two and three agree
`timescale 1ns/1ns
module tecc_sync3 (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous level in, filtered level out
  input wire logic din,
  output logic dout
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 1'h0;
      s2_r <= 1'h0;
      s3_r <= 1'h0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dout <= 1'h0;
    end else if (s2_r == s3_r) begin
      dout <= s3_r;
    end
  end

endmodule

// ===== tecc_counter.sv
// Purpose: Free-running 40-bit elapsed-time counter with triggered capture
// Assumes: Read strobes and configuration come from same-clock serial logic
// Notes: Oscillator inputs are sampled, so they must run well below CLK / 4
`timescale 1ns/1ns

// How it works
// - Pin with function 0x27 captures on edge
// - Polarity invert chooses which pin edge triggers
// - Pin capture holds until low byte read
// - Source select: 1 pin, 0 chip-select fall
// - Chip-select capture readable within same transaction
// - Select 0: third oscillator divided by 8
// - Select 1: second oscillator divided by 20
// - Counter wraps silently at 40-bit maximum
// - Enable low holds counter at zero
// - Capture equals time since enable rose
// - Oscillator select also steers reference validation
// - Chip-select mode locks after high-byte read
// - Capture shown as five byte registers
module tecc_counter (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Oscillator inputs
  input wire logic THIRD_OSCILLATOR,
  input wire logic SECOND_OSCILLATOR,
  // Configuration
  input wire logic COUNTER_OSCILLATOR_SELECT,
  input wire logic ELAPSED_COUNTER_ENABLE,
  input wire logic CAPTURE_SOURCE_SELECT,
  input wire logic [tecc_pkg::FUNC_W-1:0] PIN_FUNCTION_SELECT,
  input wire logic PIN_POLARITY_INVERT,
  // Trigger pins
  input wire logic TRIGGER_PIN,
  input wire logic SERIAL_CHIP_SELECT_N,
  // Host byte-read strobes
  input wire logic READ_LOW_BYTE,
  input wire logic READ_HIGH_BYTE,
  // Captured value bytes
  output logic [7:0] CAPTURE_BYTE0,
  output logic [7:0] CAPTURE_BYTE1,
  output logic [7:0] CAPTURE_BYTE2,
  output logic [7:0] CAPTURE_BYTE3,
  output logic [7:0] CAPTURE_BYTE4,
  // Status
  output logic CAPTURE_LOCKED,
  output logic VALIDATION_OSC_SELECT
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic third_lvl;
  logic second_lvl;
  logic trig_lvl;
  logic cs_lvl;

  tecc_sync3 u_sync_third (
    .clk(CLK),
    .resetn(RESETN),
    .din(THIRD_OSCILLATOR),
    .dout(third_lvl)
  );

  tecc_sync3 u_sync_second (
    .clk(CLK),
    .resetn(RESETN),
    .din(SECOND_OSCILLATOR),
    .dout(second_lvl)
  );

  // Trigger and chip select enter the count domain here
  tecc_sync3 u_sync_trig (
    .clk(CLK),
    .resetn(RESETN),
    .din(TRIGGER_PIN),
    .dout(trig_lvl)
  );

  // Select enters inverted so its idle level matches the synchroniser reset
  tecc_sync3 u_sync_cs (
    .clk(CLK),
    .resetn(RESETN),
    .din(!SERIAL_CHIP_SELECT_N),
    .dout(cs_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter clock divider

  logic osc_lvl;
  logic osc_prev_r;
  logic osc_rise;
  logic [tecc_pkg::DIV_W-1:0] div_limit;
  logic [tecc_pkg::DIV_W-1:0] div_cnt_r;
  logic [tecc_pkg::DIV_W-1:0] div_cnt_nxt;
  logic tick;

  // Switching the select may insert one short or long tick
  assign osc_lvl = (COUNTER_OSCILLATOR_SELECT == tecc_pkg::OSC_SEL_SECOND) ?
                   second_lvl : third_lvl;
  assign osc_rise = osc_lvl && !osc_prev_r;
  assign div_limit = (COUNTER_OSCILLATOR_SELECT == tecc_pkg::OSC_SEL_SECOND) ?
                     tecc_pkg::DIV_SECOND : tecc_pkg::DIV_THIRD;
  assign tick = osc_rise && (div_cnt_r >= div_limit - tecc_pkg::DIV_ONE);
  assign div_cnt_nxt = tick ? tecc_pkg::DIV_RESET : div_cnt_r + tecc_pkg::DIV_ONE;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      osc_prev_r <= 1'h0;
    end else begin
      osc_prev_r <= osc_lvl;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_cnt_r <= tecc_pkg::DIV_RESET;
    end else if (!ELAPSED_COUNTER_ENABLE) begin
      div_cnt_r <= tecc_pkg::DIV_RESET;
    end else if (osc_rise) begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Elapsed counter

  logic [tecc_pkg::CNT_W-1:0] count_r;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      count_r <= tecc_pkg::CNT_RESET;
    end else if (!ELAPSED_COUNTER_ENABLE) begin
      count_r <= tecc_pkg::CNT_RESET;
    end else if (tick) begin
      count_r <= count_r + tecc_pkg::CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger edge detection

  logic trig_prev_r;
  logic cs_prev_r;
  logic trig_eff;
  logic pin_edge;
  logic cs_fall;
  logic pin_mode;

  assign trig_eff = trig_lvl ^ PIN_POLARITY_INVERT;
  assign pin_edge = trig_eff && !trig_prev_r;
  assign cs_fall = cs_lvl && !cs_prev_r;
  assign pin_mode = (CAPTURE_SOURCE_SELECT == tecc_pkg::SRC_PIN) &&
                    (PIN_FUNCTION_SELECT == tecc_pkg::PIN_FUNC_CAPTURE);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      trig_prev_r <= 1'h0;
      cs_prev_r <= 1'h0;
    end else begin
      trig_prev_r <= trig_eff;
      cs_prev_r <= cs_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arming state and capture

  tecc_pkg::tecc_arm_t arm_r;
  tecc_pkg::tecc_arm_t arm_nxt;
  logic capture;
  logic [tecc_pkg::CNT_W-1:0] cap_r;

  assign capture = ELAPSED_COUNTER_ENABLE && (arm_r == tecc_pkg::TECC_ARMED) &&
                   (pin_mode ? pin_edge :
                    (CAPTURE_SOURCE_SELECT == tecc_pkg::SRC_CHIP_SELECT) && cs_fall);

  // A lock event in the same cycle as a low-byte read keeps the lock
  always_comb begin
    arm_nxt = arm_r;
    case (arm_r)
      tecc_pkg::TECC_ARMED: begin
        if (capture && pin_mode) begin
          arm_nxt = tecc_pkg::TECC_LOCKED;
        end else if ((CAPTURE_SOURCE_SELECT == tecc_pkg::SRC_CHIP_SELECT) &&
                     READ_HIGH_BYTE) begin
          arm_nxt = tecc_pkg::TECC_LOCKED;
        end
      end
      tecc_pkg::TECC_LOCKED: begin
        if (READ_LOW_BYTE) begin
          arm_nxt = tecc_pkg::TECC_ARMED;
        end
      end
      default: begin
        arm_nxt = tecc_pkg::TECC_ARMED;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      arm_r <= tecc_pkg::TECC_ARMED;
    end else begin
      arm_r <= arm_nxt;
    end
  end

  // Whole 40-bit word taken in one edge, so bytes never tear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cap_r <= tecc_pkg::CNT_RESET;
    end else if (capture) begin
      cap_r <= count_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign CAPTURE_BYTE0 = cap_r[7:0];
  assign CAPTURE_BYTE1 = cap_r[15:8];
  assign CAPTURE_BYTE2 = cap_r[23:16];
  assign CAPTURE_BYTE3 = cap_r[31:24];
  assign CAPTURE_BYTE4 = cap_r[39:32];
  // Only the locked state has bit 0 set, so the flag is the flip-flop itself
  assign CAPTURE_LOCKED = arm_r[0];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      VALIDATION_OSC_SELECT <= tecc_pkg::OSC_SEL_THIRD;
    end else begin
      VALIDATION_OSC_SELECT <= COUNTER_OSCILLATOR_SELECT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_pin_capture;
    @(posedge CLK) disable iff (!RESETN)
    (ELAPSED_COUNTER_ENABLE && pin_mode && (arm_r == tecc_pkg::TECC_ARMED) && pin_edge)
    |=> (cap_r == $past(count_r)) && CAPTURE_LOCKED;
  endproperty
  a_pin_capture: assert property (p_pin_capture) else $error("pin edge missed capture");

  property p_polarity;
    @(posedge CLK) disable iff (!RESETN)
    (pin_mode && !PIN_POLARITY_INVERT && $fell(trig_lvl) && !CAPTURE_LOCKED)
    |=> $stable(cap_r);
  endproperty
  a_polarity: assert property (p_polarity) else $error("falling edge captured");

  property p_pin_hold;
    @(posedge CLK) disable iff (!RESETN)
    (CAPTURE_LOCKED && pin_mode) |=> $stable(cap_r);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("locked capture changed");

  property p_cs_capture;
    @(posedge CLK) disable iff (!RESETN)
    (ELAPSED_COUNTER_ENABLE && !CAPTURE_SOURCE_SELECT && !CAPTURE_LOCKED && $rose(cs_lvl))
    |=> (cap_r == $past(count_r));
  endproperty
  a_cs_capture: assert property (p_cs_capture) else $error("chip select missed capture");

  property p_div_bound;
    @(posedge CLK) disable iff (!RESETN)
    ELAPSED_COUNTER_ENABLE |-> (div_cnt_r < tecc_pkg::DIV_SECOND);
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("divider overran");

  property p_wrap;
    @(posedge CLK) disable iff (!RESETN)
    (ELAPSED_COUNTER_ENABLE && tick && (count_r == tecc_pkg::CNT_MAX))
    ##1 ELAPSED_COUNTER_ENABLE |-> (count_r == tecc_pkg::CNT_RESET);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_hold_zero;
    @(posedge CLK) disable iff (!RESETN)
    !ELAPSED_COUNTER_ENABLE |=> (count_r == tecc_pkg::CNT_RESET);
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("counter not held at zero");

  property p_cs_lock;
    @(posedge CLK) disable iff (!RESETN)
    (!CAPTURE_SOURCE_SELECT && READ_HIGH_BYTE && !CAPTURE_LOCKED) |=> CAPTURE_LOCKED;
  endproperty
  a_cs_lock: assert property (p_cs_lock) else $error("high byte read did not lock");

  property p_step;
    @(posedge CLK) disable iff (!RESETN)
    (ELAPSED_COUNTER_ENABLE && !tick) ##1 ELAPSED_COUNTER_ENABLE |-> $stable(count_r);
  endproperty
  a_step: assert property (p_step) else $error("counter moved without tick");

  c_pin_capture: cover property (@(posedge CLK) disable iff (!RESETN)
    capture && pin_mode);
  c_cs_capture: cover property (@(posedge CLK) disable iff (!RESETN)
    capture && !CAPTURE_SOURCE_SELECT);
  c_rearm: cover property (@(posedge CLK) disable iff (!RESETN)
    CAPTURE_LOCKED ##1 !CAPTURE_LOCKED);

endmodule

// ===== tecc_far_end.sv
// Purpose: Far-side model: two oscillators and the external trigger source
// Assumes: Oscillators run well below CLK / 4 so the sampled inputs see every edge
// Notes: Trigger level changes only at falling CLK edges
`timescale 1ns/1ns
module tecc_far_end (
  // Clock
  input wire logic clk,
  // Oscillators and trigger toward the device
  output logic osc_third,
  output logic osc_second,
  output logic trig
);
  int n3 = 0;
  int n2 = 0;

  initial begin
    osc_third = 1'b0;
    osc_second = 1'b0;
    trig = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Third oscillator period 8 CLK, second 10 CLK
  always @(negedge clk) begin
    n3 = (n3 == 3) ? 0 : n3 + 1;
    n2 = (n2 == 4) ? 0 : n2 + 1;
    if (n3 == 0) osc_third <= ~osc_third;
    if (n2 == 0) osc_second <= ~osc_second;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Callers hold each level for several cycles before changing it again
  task automatic set_trig(input logic v);
    @(negedge clk);
    trig = v;
  endtask
endmodule

// ===== time_elapsed_capture_counter_test.sv
// Purpose: Self-checking bench for the elapsed-time capture counter
// Assumes: Far-side model supplies oscillators and trigger pin
// Notes: Captured counts are checked against elapsed cycles within one tick
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s expected %0h seen %0h", n, e, g); end end
module time_elapsed_capture_counter_test;
  logic CLK = 1'b0;
  logic RESETN;
  logic OSC3, OSC2, TRIG, OSCSEL, EN, SRC, POL;
  logic CS_N, RD_LO, RD_HI, LOCKED, VSEL;
  logic [7:0] FUNC;
  logic [7:0] B0, B1, B2, B3, B4;
  logic [39:0] first;
  int fail_count = 0;
  int checks = 0;

  always #10 CLK = ~CLK;

  tecc_far_end far (.clk(CLK), .osc_third(OSC3), .osc_second(OSC2), .trig(TRIG));

  tecc_counter dut (.CLK(CLK), .RESETN(RESETN), .THIRD_OSCILLATOR(OSC3),
    .SECOND_OSCILLATOR(OSC2), .COUNTER_OSCILLATOR_SELECT(OSCSEL),
    .ELAPSED_COUNTER_ENABLE(EN), .CAPTURE_SOURCE_SELECT(SRC), .PIN_FUNCTION_SELECT(FUNC),
    .PIN_POLARITY_INVERT(POL), .TRIGGER_PIN(TRIG), .SERIAL_CHIP_SELECT_N(CS_N),
    .READ_LOW_BYTE(RD_LO), .READ_HIGH_BYTE(RD_HI), .CAPTURE_BYTE0(B0),
    .CAPTURE_BYTE1(B1), .CAPTURE_BYTE2(B2), .CAPTURE_BYTE3(B3), .CAPTURE_BYTE4(B4),
    .CAPTURE_LOCKED(LOCKED), .VALIDATION_OSC_SELECT(VSEL));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [39:0] cap();
    return {B4, B3, B2, B1, B0};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task automatic pulse_lo();
    @(negedge CLK) RD_LO = 1'b1;
    @(negedge CLK) RD_LO = 1'b0;
    tick(50);
  endtask

  // Enable toggled off and on; trigger kept away from the rising enable
  task automatic restart();
    @(negedge CLK) EN = 1'b0;
    tick(4);
    EN = 1'b1;
  endtask

  task automatic in_range(input string n, input int lo, input int hi);
    `CHK(n, 1'b1, (cap() >= 40'(lo) && cap() <= 40'(hi)))
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("cap", 40'h00_0000_0000, cap())
    `CHK("locked", 1'b0, LOCKED)
    $display("test reset done");
  endtask

  task automatic t_pin();
    restart();
    tick(2000);
    far.set_trig(1'b1);
    tick(8);
    in_range("cap", 30, 32);
    `CHK("locked", 1'b1, LOCKED)
    first = cap();
    far.set_trig(1'b0);
    tick(6);
    far.set_trig(1'b1);
    tick(8);
    `CHK("cap", first, cap())
    pulse_lo();
    `CHK("locked", 1'b0, LOCKED)
    POL = 1'b1;
    tick(6);
    far.set_trig(1'b0);
    tick(8);
    `CHK("locked", 1'b1, LOCKED)
    pulse_lo();
    FUNC = 8'h26;
    POL = 1'b0;
    tick(6);
    far.set_trig(1'b1);
    tick(8);
    `CHK("locked", 1'b0, LOCKED)
    far.set_trig(1'b0);
    FUNC = 8'h27;
    tick(6);
    $display("test pin done");
  endtask

  task automatic t_cs();
    SRC = 1'b0;
    restart();
    tick(640);
    CS_N = 1'b0;
    tick(8);
    in_range("cap", 9, 11);
    `CHK("locked", 1'b0, LOCKED)
    @(negedge CLK) RD_HI = 1'b1;
    @(negedge CLK) RD_HI = 1'b0;
    CS_N = 1'b1;
    tick(2);
    `CHK("locked", 1'b1, LOCKED)
    first = cap();
    tick(200);
    CS_N = 1'b0;
    tick(8);
    `CHK("cap", first, cap())
    pulse_lo();
    `CHK("locked", 1'b0, LOCKED)
    CS_N = 1'b1;
    tick(6);
    restart();
    tick(10);
    CS_N = 1'b0;
    tick(8);
    in_range("cap", 0, 1);
    CS_N = 1'b1;
    tick(6);
    $display("test chip select done");
  endtask

  task automatic t_second();
    OSCSEL = 1'b1;
    SRC = 1'b1;
    tick(2);
    `CHK("vsel", 1'b1, VSEL)
    restart();
    tick(4000);
    far.set_trig(1'b1);
    tick(8);
    in_range("cap", 19, 21);
    far.set_trig(1'b0);
    pulse_lo();
    OSCSEL = 1'b0;
    tick(2);
    `CHK("vsel", 1'b0, VSEL)
    $display("test second oscillator done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge CLK);
    fail_count++;
    conclude();
  end

  initial begin
    RESETN = 1'b0;
    OSCSEL = 1'b0;
    EN = 1'b0;
    SRC = 1'b1;
    POL = 1'b0;
    CS_N = 1'b1;
    RD_LO = 1'b0;
    RD_HI = 1'b0;
    FUNC = 8'h27;
    repeat (20) @(posedge CLK);
    @(negedge CLK) RESETN = 1'b1;
    tick(2);
    t_reset();
    t_pin();
    t_cs();
    t_second();
    conclude();
  end
endmodule
